// *** design/vemc_regs.svh ***
/*
 * register map, field positions, reset values and fixed levels of the
 * video encoder mode control bank.
 * assumes a 32-bit apb slave: register index times four is the byte address.
 */
`ifndef VEMC_REGS_SVH
`define VEMC_REGS_SVH

// ---------------------------------------------------------------
// register indices and byte addresses
// ---------------------------------------------------------------
`define VEMC_IDX_FDC        8'h01
`define VEMC_IDX_PGL        8'h02
`define VEMC_IDX_ORT        8'h03
`define VEMC_IDX_CFG        8'h04
`define VEMC_IDX_STS        8'h05
`define VEMC_ADDR_FDC       8'h04
`define VEMC_ADDR_PGL       8'h08
`define VEMC_ADDR_ORT       8'h0c
`define VEMC_ADDR_CFG       8'h10
`define VEMC_ADDR_STS       8'h14

// ---------------------------------------------------------------
// field_dac_colorbar_control bits
// ---------------------------------------------------------------
`define VEMC_FDC_INTERLACE  0
`define VEMC_FDC_CAP_LO     1
`define VEMC_FDC_CAP_HI     2
`define VEMC_FDC_DAC_C      3
`define VEMC_FDC_DAC_D      4
`define VEMC_FDC_DAC_B      5
`define VEMC_FDC_DAC_A      6
`define VEMC_FDC_BARS       7

// ---------------------------------------------------------------
// pixel_genlock_line_control bits
// ---------------------------------------------------------------
`define VEMC_PGL_SQPIX      0
`define VEMC_PGL_PIN_IN     1
`define VEMC_PGL_PIN_FUNC   2
`define VEMC_PGL_LINE_LEN   3
`define VEMC_PGL_CHROMA     4
`define VEMC_PGL_BURST      5
`define VEMC_PGL_LOWPWR     6
`define VEMC_PGL_RSVD       7

// ---------------------------------------------------------------
// own configuration bits and output_routing bits
// ---------------------------------------------------------------
`define VEMC_CFG_COMPOSITE  0
`define VEMC_CFG_SLAVE      1
`define VEMC_CFG_PAL        2
`define VEMC_ORT_RW_LO      2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define VEMC_RST_FDC        8'h00
`define VEMC_RST_PGL        8'h00
`define VEMC_RST_ORT        6'h00
`define VEMC_RST_CFG        3'h1

// ---------------------------------------------------------------
// fixed levels: line lengths, bar levels (0.1 %), clocks (kHz)
// ---------------------------------------------------------------
`define VEMC_LINE_FULL      10'd720
`define VEMC_LINE_NTSC_AN   10'd710
`define VEMC_LINE_PAL_AN    10'd702
`define VEMC_BAR_NTSC_HI    10'd750
`define VEMC_BAR_NTSC_LO    10'd75
`define VEMC_BAR_PAL_HI     10'd1000
`define VEMC_BAR_PAL_LO     10'd0
`define VEMC_CLK_SQ_NTSC    15'd24540
`define VEMC_CLK_SQ_PAL     15'd29500
`define VEMC_CUR_FULL       7'd100
`define VEMC_CUR_LOW        7'd55

`endif

// *** design/vemc_pkg.sv ***
/*
 * types shared by the mode control bank and its pin synchroniser.
 * assumes the constants of vemc_regs.svh for all figures.
 */
package vemc_pkg;

    // ---------------------------------------------------------------
    // enumerations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        VEMC_CAP_NONE = 2'b00,
        VEMC_CAP_ODD  = 2'b01,
        VEMC_CAP_EVEN = 2'b10,
        VEMC_CAP_BOTH = 2'b11
    } vemc_cap_t;

    typedef enum logic {
        VEMC_BUS_IDLE   = 1'b0,
        VEMC_BUS_ANSWER = 1'b1
    } vemc_bus_t;

    // ---------------------------------------------------------------
    // state records
    // ---------------------------------------------------------------
    typedef struct packed {
        logic s1;    // first stage, read only by s2
        logic s2;    // settled pin level
        logic s3;    // previous settled level
    } vemc_sync_t;

    typedef struct packed {
        vemc_bus_t   bus;
        logic [7:0]  fdc;
        logic [7:0]  pgl;
        logic [5:0]  ort;
        logic [2:0]  cfg;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        interlace;
        logic        cap_odd;
        logic        cap_even;
        logic [3:0]  dac_on;
        logic        bars;
        logic [9:0]  bar_hi;
        logic [9:0]  bar_lo;
        logic        master;
        logic        sqpix;
        logic [14:0] clk_khz;
        logic        pin_oe;
        logic        sc_reset;
        logic        rtc_active;
        logic        rtc_level;
        logic [9:0]  line_px;
        logic        chroma;
        logic        burst;
        logic        low_power;
        logic [6:0]  cur_pct;
    } vemc_state_t;

endpackage

// *** design/vemc_pin_sync.sv ***
/*
 * two-stage synchroniser with falling-edge detect for the genlock pin.
 * assumes the pin is asynchronous to pclk; outputs are on pclk.
 */
`timescale 1ns/1ps
module vemc_pin_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_async,
    output logic      pin_level,
    output logic      pin_fall
);
    import vemc_pkg::*;

    vemc_sync_t st_q;   // all stages
    vemc_sync_t st_d;   // next stages

    // ---------------------------------------------------------------
    // next stage values
    // ---------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_async;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    // ---------------------------------------------------------------
    // stage registers; idle-high pin assumed at reset
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= 3'b111;
        end else begin
            st_q <= st_d;
        end
    end

    // edge seen only between settled stages, never on s1
    assign pin_level = st_q.s2;
    assign pin_fall  = st_q.s3 & ~st_q.s2;

endmodule

// *** design/vemc_top.sv ***
/*
 * apb register bank for the encoder mode controls, with the derived
 * controls handed to the video pipeline and the genlock pin handling.
 * assumes one 20 MHz pclk domain and an apb master obeying the protocol.
 */
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "vemc_regs.svh"

// Behaviour
// - bit selects interlaced or progressive output
// - interlace matters only in composite mode
// - two-bit field picks caption fields
// - one power-down bit per dac
// - 0 keeps dac on; order C,D,B,A
// - colour bars with standard-dependent levels
// - colour bars force master timing
// - square pixel only in slave timing
// - genlock bit one makes pin input
// - pin falling edge resets subcarrier phase
// - pin as real-time lock input
// - active line 720, or 710/702
// - chroma gate bit
// - burst gate bit
// - low power cuts dac current 45%
module vemc_top #(
    parameter logic [1:0] REVISION = 2'h0  // arbitrary revision code
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        subcarrier_lock_pin_i,
    output logic             subcarrier_lock_pin_o,
    output logic             subcarrier_lock_pin_oe,
    output logic             interlace_select,
    output logic             caption_odd_enable,
    output logic             caption_even_enable,
    output logic [3:0]       dac_power_on,
    output logic             test_bars_enable,
    output logic [9:0]       bars_high_level,
    output logic [9:0]       bars_low_level,
    output logic             timing_master,
    output logic             square_pixel_enable,
    output logic [14:0]      pixel_clock_khz,
    output logic             subcarrier_phase_reset,
    output logic             rtc_lock_active,
    output logic             rtc_lock_level,
    output logic [9:0]       active_line_pixels,
    output logic             chroma_gate,
    output logic             burst_gate,
    output logic             dac_low_power_enable,
    output logic [6:0]       dac_current_pct,
    output logic [5:0]       output_routing_bits
);
    import vemc_pkg::*;

    // ---------------------------------------------------------------
    // state and pin synchroniser
    // ---------------------------------------------------------------
    vemc_state_t st_q;        // whole block state
    vemc_state_t st_d;        // next state
    logic        pin_level;   // settled pin level
    logic        pin_fall;    // settled high-to-low step
    logic        wr_commit;   // write takes effect this edge
    logic        pal;         // standard select from config
    logic        pin_in;      // pin configured as input

    vemc_pin_sync u_pin_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (subcarrier_lock_pin_i),
        .pin_level (pin_level),
        .pin_fall  (pin_fall)
    );

    assign wr_commit = psel & penable & pwrite & st_q.pready;

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        st_d          = st_q;
        st_d.pready   = 1'b0;
        st_d.sc_reset = 1'b0;
        unique case (st_q.bus)
            // access seen: answer after one wait cycle
            VEMC_BUS_IDLE: begin
                if (psel & penable) begin
                    st_d.bus     = VEMC_BUS_ANSWER;
                    st_d.pready  = 1'b1;
                    st_d.pslverr = 1'b0;
                    st_d.prdata  = 32'h0000_0000;
                    unique case (paddr)
                        `VEMC_ADDR_FDC: st_d.prdata[7:0] = st_q.fdc;
                        // reserved top bit reads back as written
                        `VEMC_ADDR_PGL: st_d.prdata[7:0] = st_q.pgl;
                        `VEMC_ADDR_ORT: begin
                            st_d.prdata[7:0] = {st_q.ort, REVISION};
                        end
                        `VEMC_ADDR_CFG: st_d.prdata[2:0] = st_q.cfg;
                        `VEMC_ADDR_STS: begin
                            st_d.prdata[7:0] = {st_q.dac_on, st_q.rtc_active,
                                st_q.sqpix, st_q.interlace, st_q.master};
                        end
                        // unmapped: error answer, reads zero
                        default: st_d.pslverr = 1'b1;
                    endcase
                end
            end
            // answer edge: write lands here and nowhere else
            VEMC_BUS_ANSWER: begin
                st_d.bus = VEMC_BUS_IDLE;
                if (wr_commit) begin
                    unique case (paddr)
                        `VEMC_ADDR_FDC: st_d.fdc = pwdata[7:0];
                        `VEMC_ADDR_PGL: st_d.pgl = pwdata[7:0];
                        `VEMC_ADDR_ORT: st_d.ort = pwdata[7:2];
                        `VEMC_ADDR_CFG: st_d.cfg = pwdata[2:0];
                        // status is read only; unmapped ignored
                        default: st_d.pslverr = st_q.pslverr;
                    endcase
                end
            end
        endcase

        // derived controls follow the new register values at once
        pal    = st_d.cfg[`VEMC_CFG_PAL];
        pin_in = st_d.pgl[`VEMC_PGL_PIN_IN];
        // composite mode gates interlace
        st_d.interlace = st_d.fdc[`VEMC_FDC_INTERLACE]
                       & st_d.cfg[`VEMC_CFG_COMPOSITE];
        // caption field decode
        st_d.cap_odd  = st_d.fdc[`VEMC_FDC_CAP_LO];
        st_d.cap_even = st_d.fdc[`VEMC_FDC_CAP_HI];
        // per-dac enables, A,B,C,D from msb; 1 in a bit powers it off
        st_d.dac_on = ~{st_d.fdc[`VEMC_FDC_DAC_A], st_d.fdc[`VEMC_FDC_DAC_B],
                        st_d.fdc[`VEMC_FDC_DAC_C],
                        st_d.fdc[`VEMC_FDC_DAC_D]};
        // bar levels by standard
        st_d.bars   = st_d.fdc[`VEMC_FDC_BARS];
        st_d.bar_hi = pal ? `VEMC_BAR_PAL_HI : `VEMC_BAR_NTSC_HI;
        st_d.bar_lo = pal ? `VEMC_BAR_PAL_LO : `VEMC_BAR_NTSC_LO;
        // bars override any slave setting
        st_d.master = st_d.bars | ~st_d.cfg[`VEMC_CFG_SLAVE];
        // square pixel needs slave timing; host supplies the clock
        st_d.sqpix   = st_d.pgl[`VEMC_PGL_SQPIX] & ~st_d.master;
        st_d.clk_khz = pal ? `VEMC_CLK_SQ_PAL : `VEMC_CLK_SQ_NTSC;
        // pin driven low only when not configured as input
        st_d.pin_oe = ~pin_in;
        // subcarrier reset on each settled falling edge while the pin is an input and the function bit is clear
        if (pin_in & ~st_d.pgl[`VEMC_PGL_PIN_FUNC] & pin_fall) begin
            st_d.sc_reset = 1'b1;
        end
        // real-time lock input passes the settled level on
        st_d.rtc_active = pin_in & st_d.pgl[`VEMC_PGL_PIN_FUNC];
        st_d.rtc_level  = st_d.rtc_active & pin_level;
        // active line length
        if (!st_d.pgl[`VEMC_PGL_LINE_LEN]) begin
            st_d.line_px = `VEMC_LINE_FULL;
        end else begin
            st_d.line_px = pal ? `VEMC_LINE_PAL_AN : `VEMC_LINE_NTSC_AN;
        end
        st_d.chroma    = st_d.pgl[`VEMC_PGL_CHROMA];
        st_d.burst     = st_d.pgl[`VEMC_PGL_BURST];
        // low power trims dac current to 55 %
        st_d.low_power = st_d.pgl[`VEMC_PGL_LOWPWR];
        st_d.cur_pct   = st_d.low_power ? `VEMC_CUR_LOW : `VEMC_CUR_FULL;
    end

    // ---------------------------------------------------------------
    // state register; derived fields match the reset register values
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q            <= '0;
            st_q.bus        <= VEMC_BUS_IDLE;
            st_q.fdc        <= `VEMC_RST_FDC;
            st_q.pgl        <= `VEMC_RST_PGL;
            st_q.ort        <= `VEMC_RST_ORT;
            st_q.cfg        <= `VEMC_RST_CFG;
            st_q.dac_on     <= 4'hf;
            st_q.bar_hi     <= `VEMC_BAR_NTSC_HI;
            st_q.bar_lo     <= `VEMC_BAR_NTSC_LO;
            st_q.master     <= 1'b1;
            st_q.clk_khz    <= `VEMC_CLK_SQ_NTSC;
            st_q.pin_oe     <= 1'b1;
            st_q.line_px    <= `VEMC_LINE_FULL;
            st_q.cur_pct    <= `VEMC_CUR_FULL;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all straight from the state register except the tied-low subcarrier_lock_pin_o
    // ---------------------------------------------------------------
    assign prdata                 = st_q.prdata;
    assign pready                 = st_q.pready;
    assign pslverr                = st_q.pslverr;
    assign subcarrier_lock_pin_o  = 1'b0;
    assign subcarrier_lock_pin_oe = st_q.pin_oe;
    assign interlace_select       = st_q.interlace;
    assign caption_odd_enable     = st_q.cap_odd;
    assign caption_even_enable    = st_q.cap_even;
    assign dac_power_on           = st_q.dac_on;
    assign test_bars_enable       = st_q.bars;
    assign bars_high_level        = st_q.bar_hi;
    assign bars_low_level         = st_q.bar_lo;
    assign timing_master          = st_q.master;
    assign square_pixel_enable    = st_q.sqpix;
    assign pixel_clock_khz        = st_q.clk_khz;
    assign subcarrier_phase_reset = st_q.sc_reset;
    assign rtc_lock_active        = st_q.rtc_active;
    assign rtc_lock_level         = st_q.rtc_level;
    assign active_line_pixels     = st_q.line_px;
    assign chroma_gate            = st_q.chroma;
    assign burst_gate             = st_q.burst;
    assign dac_low_power_enable   = st_q.low_power;
    assign dac_current_pct        = st_q.cur_pct;
    assign output_routing_bits    = st_q.ort;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_fdc_write;
        wr_commit && paddr == `VEMC_ADDR_FDC;
    endsequence

    sequence seq_pin_fall_reset;
        pin_fall && pin_in && !st_d.pgl[`VEMC_PGL_PIN_FUNC];
    endsequence

    sequence seq_setup;
        psel && !penable && st_q.bus == VEMC_BUS_IDLE;
    endsequence

    AST_INTERLACE_COMPOSITE: assert property (
        !st_q.cfg[`VEMC_CFG_COMPOSITE] |-> !interlace_select)
        else $error("interlace active outside composite mode");

    AST_CAPTION_EVEN: assert property (
        caption_even_enable == (st_q.fdc[2:1] == VEMC_CAP_EVEN
                             || st_q.fdc[2:1] == VEMC_CAP_BOTH))
        else $error("even caption enable disagrees with field code");

    AST_DAC_A_ORDER: assert property (
        dac_power_on[3] == !st_q.fdc[`VEMC_FDC_DAC_A]
        && dac_power_on[1] == !st_q.fdc[`VEMC_FDC_DAC_C])
        else $error("dac enable order wrong");

    AST_BARS_MASTER: assert property (
        test_bars_enable |-> timing_master)
        else $error("colour bars without master timing");

    AST_SQPIX_SLAVE: assert property (
        square_pixel_enable |-> !timing_master)
        else $error("square pixel active in master timing");

    AST_PIN_INPUT: assert property (
        subcarrier_lock_pin_oe == !st_q.pgl[`VEMC_PGL_PIN_IN])
        else $error("pin drive does not follow input enable");

    AST_SC_RESET: assert property (
        seq_pin_fall_reset |=> subcarrier_phase_reset ##1
        !subcarrier_phase_reset)
        else $error("subcarrier reset pulse missing or too long");

    AST_LINE_LEN: assert property (
        st_q.pgl[`VEMC_PGL_LINE_LEN] && st_q.cfg[`VEMC_CFG_PAL]
        |-> active_line_pixels == 10'd702)
        else $error("pal analog line length wrong");

    AST_LOW_POWER: assert property (
        dac_current_pct == (dac_low_power_enable ? 7'd55 : 7'd100))
        else $error("dac current figure wrong");

    AST_WRITE_HOLD: assert property (
        seq_fdc_write |=> st_q.fdc == $past(pwdata[7:0]))
        else $error("mode register write not stored");

    AST_BUS_WAIT: assert property (
        seq_setup ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("apb answer timing wrong");

endmodule

// *** dv/vemc_host.sv ***
/*
 * apb host model standing in for the encoder's control processor.
 * assumes pclk from the bench; the bench timeout cuts any hang.
 */
`timescale 1ns/1ps
`include "vemc_regs.svh"
module vemc_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ---------------------------------------------------------------
    // idle bus levels from time zero
    // ---------------------------------------------------------------
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // ---------------------------------------------------------------
    // one transfer; starts on its own edge so calls never collide
    // ---------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic err);
        logic [7:0] dv;
        dv = d;
        // host never sets the top bit of the pixel register
        if (wr && a == `VEMC_ADDR_PGL) begin
            dv[`VEMC_PGL_RSVD] = 1'b0;
        end
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, dv};
        @(posedge pclk);
        penable <= 1'b1;
        // request held until pready seen high at an edge
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q       = prdata[7:0];
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// *** dv/vemc_tb.sv ***
/*
 * self-checking bench for the mode control bank.
 * assumes vemc_host drives apb; bench drives clock, reset and pin.
 */
`timescale 1ns/1ps
`include "vemc_regs.svh"
module testbench;
    logic pclk, presetn, pin;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ilace, codd, ceven, bars, tmas, sqp, scr, rtca, rtcl;
    logic chr, bst, lpw, oe, po;
    logic [5:0] orb;
    logic [3:0] dpo;
    logic [9:0] bhi, blo, lpx;
    logic [14:0] ckhz;
    logic [6:0] cur;
    int err_total, n_tests, cyc;

    vemc_host h (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    vemc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .subcarrier_lock_pin_i(pin),
        .subcarrier_lock_pin_o(po), .subcarrier_lock_pin_oe(oe),
        .interlace_select(ilace), .caption_odd_enable(codd),
        .caption_even_enable(ceven), .dac_power_on(dpo),
        .test_bars_enable(bars), .bars_high_level(bhi),
        .bars_low_level(blo), .timing_master(tmas),
        .square_pixel_enable(sqp), .pixel_clock_khz(ckhz),
        .subcarrier_phase_reset(scr), .rtc_lock_active(rtca),
        .rtc_lock_level(rtcl), .active_line_pixels(lpx),
        .chroma_gate(chr), .burst_gate(bst),
        .dac_low_power_enable(lpw), .dac_current_pct(cur),
        .output_routing_bits(orb));

    // ---------------------------------------------------------------
    // clock, reset and timeout
    // ---------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        // a few hundred transfers fit well inside this
        if (cyc == 4000) begin
            err_total++;
            end_sim();
        end
    end

    // ---------------------------------------------------------------
    // shared helpers
    // ---------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [7:0] q;
        logic e;
        h.xfer(1'b1, a, d, q, e);
        #1; // derived outputs settle on the write edge
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] x, logic xe);
        logic [7:0] q;
        logic e;
        h.xfer(1'b0, a, 8'h00, q, e);
        chk("rdata", {24'h0, x}, {24'h0, q});
        chk("slverr", {31'h0, xe}, {31'h0, e});
    endtask
    // pulses seen on the phase reset over eight edges
    task automatic falls(output int n);
        n = 0;
        @(posedge pclk);
        pin <= 1'b0;
        repeat (8) begin
            @(posedge pclk);
            if (scr === 1'b1) n++;
        end
        pin <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk("dacs", 4'hf, dpo);
        chk("master", 1, tmas);
        chk("line", 720, lpx);
        chk("cur", 100, cur);
        rd(`VEMC_ADDR_FDC, 8'h00, 1'b0);
        rd(`VEMC_ADDR_PGL, 8'h00, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_fdc();
        int pos[4] = '{1, 0, 2, 3};
        wr(`VEMC_ADDR_FDC, 8'h01);
        chk("ilace", 1, ilace);
        wr(`VEMC_ADDR_CFG, 8'h00);
        chk("ilace_rgb", 0, ilace);
        wr(`VEMC_ADDR_CFG, 8'h01);
        chk("ilace_back", 1, ilace);
        for (int c = 0; c < 4; c++) begin
            wr(`VEMC_ADDR_FDC, 8'(c << 1));
            chk("cap", c, {ceven, codd});
        end
        // one power-down bit at a time: C, D, B, A
        for (int i = 0; i < 4; i++) begin
            wr(`VEMC_ADDR_FDC, 8'(8'h08 << i));
            chk("dac", 4'hf & ~(4'h1 << pos[i]), dpo);
        end
        wr(`VEMC_ADDR_CFG, 8'h02);
        chk("slave", 0, tmas);
        wr(`VEMC_ADDR_FDC, 8'h80);
        chk("bars", 1, bars);
        chk("forced", 1, tmas);
        chk("ntsc_hi", 750, bhi);
        chk("ntsc_lo", 75, blo);
        wr(`VEMC_ADDR_CFG, 8'h06);
        chk("pal_hi", 1000, bhi);
        chk("pal_lo", 0, blo);
        rd(`VEMC_ADDR_FDC, 8'h80, 1'b0);
        $display("test mode1 done");
    endtask
    task automatic t_pgl();
        wr(`VEMC_ADDR_PGL, 8'h01);
        chk("sq_bars", 0, sqp);
        wr(`VEMC_ADDR_FDC, 8'h00);
        chk("sq", 1, sqp);
        chk("clk_pal", 29500, ckhz);
        wr(`VEMC_ADDR_CFG, 8'h02);
        chk("clk_ntsc", 24540, ckhz);
        wr(`VEMC_ADDR_PGL, 8'hf8);
        chk("line_n", 710, lpx);
        chk("chroma", 1, chr);
        chk("burst", 1, bst);
        chk("lowp", 1, lpw);
        chk("cur55", 55, cur);
        rd(`VEMC_ADDR_PGL, 8'h78, 1'b0);
        wr(`VEMC_ADDR_CFG, 8'h06);
        chk("line_p", 702, lpx);
        wr(`VEMC_ADDR_PGL, 8'h00);
        chk("line_f", 720, lpx);
        chk("chr_off", 0, chr);
        chk("bst_off", 0, bst);
        chk("cur_f", 100, cur);
        $display("test mode2 done");
    endtask
    task automatic t_pin();
        int n;
        falls(n);
        chk("no_in", 0, n);
        wr(`VEMC_ADDR_PGL, 8'h02);
        chk("oe_off", 0, oe);
        falls(n);
        chk("pulse", 1, n);
        wr(`VEMC_ADDR_PGL, 8'h06);
        chk("rtc", 1, rtca);
        falls(n);
        chk("no_pulse", 0, n);
        @(posedge pclk);
        pin <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("rtc_lo", 0, rtcl);
        pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("rtc_hi", 1, rtcl);
        wr(`VEMC_ADDR_PGL, 8'h04);
        chk("oe_on", 1, oe);
        $display("test genlock done");
    endtask
    task automatic t_bus();
        rd(8'h40, 8'h00, 1'b1);
        wr(8'h40, 8'h5a);
        rd(`VEMC_ADDR_PGL, 8'h04, 1'b0);
        // status is read only: a write leaves it alone
        wr(`VEMC_ADDR_STS, 8'h00);
        rd(`VEMC_ADDR_STS, 8'hf0, 1'b0);
        rd(`VEMC_ADDR_CFG, 8'h06, 1'b0);
        // revision bits stay at their fixed code under a write
        wr(`VEMC_ADDR_ORT, 8'hff);
        chk("routing", 6'h3f, orb);
        rd(`VEMC_ADDR_ORT, 8'hfc, 1'b0);
        chk("pin_o", 0, po);
        $display("test bus done");
    endtask

    // ---------------------------------------------------------------
    // closing report, the single place the run ends
    // ---------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        pin = 1'b1;
        cyc = 0;
        err_total = 0;
        n_tests = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fdc();
        t_pgl();
        t_pin();
        t_bus();
        end_sim();
    end
endmodule
